// ===== verilog/mppt_pkg.sv
// Package: constants and carrier types for the register access block
package mppt_pkg;

  // ----------------------------------------------------------------
  // Bus framing
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_BASE = 8'he0;       // Command value of register 0
  localparam logic [4:0] CMD_BASE_HI = 5'h1c;    // Upper five bits shared by all commands
  localparam int DATA_BYTES = 7;                 // Bytes per data register
  localparam logic [3:0] FIRST_DATA_IDX = 4'h2;  // Frame index of first data byte
  localparam logic [3:0] LAST_DATA_IDX = 4'h8;   // Frame index of seventh data byte
  localparam logic [3:0] READ_LAST_IDX = 4'h7;   // Bytes sent when a read is complete
  localparam logic [3:0] ADDR_PAD = 4'h0;        // Upper address bits above the straps

  // ----------------------------------------------------------------
  // Register indices (command minus base)
  // ----------------------------------------------------------------
  localparam logic [2:0] IDX_STATUS0 = 3'h0;     // Read-only
  localparam logic [2:0] IDX_STATUS1 = 3'h1;     // Read-only
  localparam logic [2:0] IDX_UNUSED = 3'h2;      // Not present, refused
  localparam logic [2:0] IDX_CTRL = 3'h3;        // Control and override register
  localparam logic [2:0] IDX_TRIM = 3'h4;        // sense_offset_trim
  localparam logic [2:0] IDX_THRESH = 3'h5;      // start_current_thresholds
  localparam int NUM_RW = 3;                     // Writable registers, indices 3..5

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_OVERRIDE_BIT = 46;
  localparam int CTRL_PWR_SEL_BIT = 42;
  localparam int CTRL_MODE_LSB = 40;
  localparam int CTRL_IOUT_MAX_LSB = 30;
  localparam int CTRL_VOUT_MAX_LSB = 20;
  localparam int CTRL_DUTY_LSB = 5;
  localparam int TRIM_LSB = 0;                   // Trim fields occupy 31:0
  localparam int THR_LSB = 0;                    // Threshold fields occupy 39:0

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [55:0] CTRL_RESET = 56'h0000_00ff_fff6_dfe0;
  localparam logic [55:0] TRIM_RESET = 56'h0000_0000_0000_0000;
  localparam logic [55:0] THRESH_RESET = 56'h0000_000a_0180_a018;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] vout_offset;
    logic [7:0] iout_offset;
    logic [7:0] vin_offset;
    logic [7:0] iin_offset;
  } mppt_trim_s;

  typedef struct packed {
    logic [9:0] input_current_start_high;
    logic [9:0] input_current_start_low;
    logic [9:0] output_current_start_high;
    logic [9:0] output_current_start_low;
  } mppt_thresh_s;

  typedef struct packed {
    logic power_thr_sel;
    logic [1:0] mode_sel;
    logic [9:0] iout_max;
    logic [9:0] vout_max;
  } mppt_limits_s;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_RX_END,
    ST_ACK,
    ST_TX,
    ST_TX_ACK,
    ST_TX_NEXT
  } mppt_state_e;

endpackage

// ===== verilog/mppt_reg_bank.sv
// Register bank: writable data registers and registered read port
`timescale 1ns/1ps
`default_nettype none

module mppt_reg_bank
  import mppt_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic wr_en_in,
  input wire logic [2:0] wr_idx_in,
  input wire logic [55:0] wr_data_in,
  input wire logic [2:0] rd_idx_in,
  input wire logic [55:0] status0_in,
  input wire logic [55:0] status1_in,
  output logic [55:0] rd_data_out,
  output logic [55:0] ctrl_out,
  output logic [55:0] trim_out,
  output logic [55:0] thresh_out
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [55:0] mem_reg [NUM_RW];   // Entries for indices 3, 4, 5
  logic [55:0] mem_next [NUM_RW];
  logic [55:0] rd_reg;             // Read data, one cycle after index
  logic [55:0] rd_next;
  localparam logic [55:0] RESET_VAL [NUM_RW] = '{CTRL_RESET, TRIM_RESET, THRESH_RESET};

  genvar g;
  generate
    for (g = 0; g < NUM_RW; g++) begin : g_entry
      // Entry update; only a full commit reaches here
      always_comb begin
        mem_next[g] = mem_reg[g];
        if (wr_en_in && wr_idx_in == IDX_CTRL + 3'(g)) begin
          mem_next[g] = wr_data_in;
        end
      end

      always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
          mem_reg[g] <= RESET_VAL[g];
        end else begin
          mem_reg[g] <= mem_next[g];
        end
      end
    end
  endgenerate

  // Read mux; indices 0 and 1 come from outside and never store writes
  always_comb begin
    rd_next = 56'h0;
    case (rd_idx_in)
      IDX_STATUS0: rd_next = status0_in;
      IDX_STATUS1: rd_next = status1_in;
      IDX_CTRL: rd_next = mem_reg[0];
      IDX_TRIM: rd_next = mem_reg[1];
      IDX_THRESH: rd_next = mem_reg[2];
      default: rd_next = 56'h0;
    endcase
  end

  // Read data register
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      rd_reg <= 56'h0;
    end else begin
      rd_reg <= rd_next;
    end
  end

  assign rd_data_out = rd_reg;
  assign ctrl_out = mem_reg[0];
  assign trim_out = mem_reg[1];
  assign thresh_out = mem_reg[2];

endmodule

`default_nettype wire

// ===== verilog/mppt_i2c_register_access.sv
// Serial slave register access for a tracking controller
`timescale 1ns/1ps
`default_nettype none

module mppt_i2c_register_access
  import mppt_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic addr_strap_msb,
  input wire logic addr_strap_mid,
  input wire logic addr_strap_lsb,
  input wire logic [9:0] input_current_sample_in,
  input wire logic [9:0] output_current_sample_in,
  input wire logic [55:0] status0_in,
  input wire logic [55:0] status1_in,
  input wire mppt_limits_s sensed_limits_in,
  output mppt_limits_s limits_out,
  output logic override_out,
  output logic [8:0] pwm_duty_out,
  output mppt_trim_s trim_out,
  output mppt_thresh_s thresh_out,
  output logic tracking_out
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [2:0] scl_sync_reg, scl_sync_next;   // Two sync stages plus history
  logic [2:0] sda_sync_reg, sda_sync_next;
  logic [2:0] strap_meta_reg, strap_meta_next;
  logic [2:0] strap_reg, strap_next;          // Synchronised straps
  logic [6:0] addr_reg, addr_next;            // Own slave address
  mppt_state_e state_reg, state_next;
  logic [2:0] bit_cnt_reg, bit_cnt_next;      // Bit within byte
  logic [3:0] byte_idx_reg, byte_idx_next;    // Frame within transfer
  logic [7:0] shift_reg, shift_next;          // Receive shifter
  logic rw_reg, rw_next;                      // 1 while reading
  logic [7:0] cmd_reg, cmd_next;              // Last accepted command
  logic [55:0] wbuf_reg, wbuf_next;           // Write assembly
  logic [55:0] tx_reg, tx_next;               // Read bytes left to send
  logic oe_reg, oe_next;                      // Pulls the data line low
  logic wr_reg, wr_next;                      // One-cycle commit pulse
  logic track_reg, track_next;
  mppt_limits_s limits_reg, limits_next;
  logic ovr_reg, ovr_next;
  logic [8:0] duty_reg, duty_next;
  mppt_trim_s trim_reg, trim_next;
  mppt_thresh_s thr_reg, thr_next;
  logic scl_s, scl_d, sda_s, sda_d;
  logic scl_rise, scl_fall, start_cond, stop_cond;
  logic [55:0] rd_data, ctrl_val, trim_val, thresh_val;
  logic cmd_ok;
  logic ack;

  // ----------------------------------------------------------------
  // Register bank
  // ----------------------------------------------------------------
  mppt_reg_bank u_bank (
    .core_clk_in(core_clk_in),
    .srst_in(srst_in),
    .wr_en_in(wr_reg),
    .wr_idx_in(cmd_reg[2:0]),
    .wr_data_in(wbuf_reg),
    .rd_idx_in(cmd_reg[2:0]),
    .status0_in(status0_in),
    .status1_in(status1_in),
    .rd_data_out(rd_data),
    .ctrl_out(ctrl_val),
    .trim_out(trim_val),
    .thresh_out(thresh_val)
  );

  // ----------------------------------------------------------------
  // Line conditions, read only from second stage onward
  // ----------------------------------------------------------------
  assign scl_s = scl_sync_reg[1];
  assign scl_d = scl_sync_reg[2];
  assign sda_s = sda_sync_reg[1];
  assign sda_d = sda_sync_reg[2];
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_cond = scl_s & scl_d & ~sda_d & sda_s;
  assign cmd_ok = (shift_reg[7:3] == CMD_BASE_HI) && (shift_reg[2:0] <= IDX_THRESH) &&
                  (shift_reg[2:0] != IDX_UNUSED);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    scl_sync_next = {scl_sync_reg[1:0], scl_in};
    sda_sync_next = {sda_sync_reg[1:0], sda_in};
    strap_meta_next = {addr_strap_msb, addr_strap_mid, addr_strap_lsb};
    strap_next = strap_meta_reg;
    // strap address, first strap on top
    addr_next = {ADDR_PAD, strap_reg};
    state_next = state_reg;
    bit_cnt_next = bit_cnt_reg;
    byte_idx_next = byte_idx_reg;
    shift_next = shift_reg;
    rw_next = rw_reg;
    cmd_next = cmd_reg;
    wbuf_next = wbuf_reg;
    tx_next = tx_reg;
    oe_next = oe_reg;
    wr_next = 1'b0;
    ack = 1'b0;
    // Start or stop abort any frame, even mid-byte
    if (start_cond) begin
      state_next = ST_RX;
      bit_cnt_next = 3'h0;
      byte_idx_next = 4'h0;
      oe_next = 1'b0;
    end else if (stop_cond) begin
      state_next = ST_IDLE;
      oe_next = 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          oe_next = 1'b0;
        end
        // Shift in one bit per rising clock
        ST_RX: begin
          if (scl_rise) begin
            shift_next = {shift_reg[6:0], sda_s};
            bit_cnt_next = bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'h7) begin
              state_next = ST_RX_END;
            end
          end
        end
        // Decide acknowledge once the eighth bit is in
        ST_RX_END: begin
          if (scl_fall) begin
            if (byte_idx_reg == 4'h0) begin
              ack = (shift_reg[7:1] == addr_reg);
              rw_next = shift_reg[0];
            end else if (byte_idx_reg == 4'h1) begin
              ack = cmd_ok;
              if (cmd_ok) begin
                cmd_next = shift_reg;
              end
            end else begin
              ack = (byte_idx_reg <= LAST_DATA_IDX);
              if (ack) begin
                wbuf_next = {shift_reg, wbuf_reg[55:8]};
              end
            end
            oe_next = ack;
            state_next = ack ? ST_ACK : ST_IDLE;
          end
        end
        // Release after the acknowledge clock
        ST_ACK: begin
          if (scl_fall) begin
            byte_idx_next = byte_idx_reg + 4'h1;
            bit_cnt_next = 3'h0;
            oe_next = 1'b0;
            if (!rw_reg && byte_idx_reg == LAST_DATA_IDX) begin
              wr_next = 1'b1;
            end
            if (rw_reg && byte_idx_reg == 4'h0) begin
              tx_next = rd_data;
              oe_next = ~rd_data[7];
              state_next = ST_TX;
            end else begin
              state_next = ST_RX;
            end
          end
        end
        // Drive bits most significant first within a byte
        ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_reg == 3'h7) begin
              oe_next = 1'b0;
              state_next = ST_TX_ACK;
            end else begin
              bit_cnt_next = bit_cnt_reg + 3'h1;
              oe_next = ~tx_reg[3'h6 - bit_cnt_reg];
            end
          end
        end
        // Master acknowledge; a refusal or the seventh byte ends the read
        ST_TX_ACK: begin
          if (scl_rise) begin
            if (!sda_s && byte_idx_reg < READ_LAST_IDX) begin
              byte_idx_next = byte_idx_reg + 4'h1;
              state_next = ST_TX_NEXT;
            end else begin
              state_next = ST_IDLE;
            end
          end
        end
        // Next byte placed after the acknowledge clock
        ST_TX_NEXT: begin
          if (scl_fall) begin
            tx_next = {8'h0, tx_reg[55:8]};
            oe_next = ~tx_reg[15];
            bit_cnt_next = 3'h0;
            state_next = ST_TX;
          end
        end
        default: begin
          state_next = ST_IDLE;
          oe_next = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Control outputs derived from the bank
  // ----------------------------------------------------------------
  always_comb begin
    trim_next = mppt_trim_s'(trim_val[TRIM_LSB +: 32]);
    thr_next = mppt_thresh_s'(thresh_val[THR_LSB +: 40]);
    duty_next = ctrl_val[CTRL_DUTY_LSB +: 9];
    ovr_next = ctrl_val[CTRL_OVERRIDE_BIT];
    if (ctrl_val[CTRL_OVERRIDE_BIT]) begin
      limits_next.power_thr_sel = ctrl_val[CTRL_PWR_SEL_BIT];
      limits_next.mode_sel = ctrl_val[CTRL_MODE_LSB +: 2];
      limits_next.iout_max = ctrl_val[CTRL_IOUT_MAX_LSB +: 10];
      limits_next.vout_max = ctrl_val[CTRL_VOUT_MAX_LSB +: 10];
    end else begin
      limits_next = sensed_limits_in;
    end
    // enter at or above both highs, leave below either low
    track_next = track_reg;
    if (!track_reg) begin
      if (input_current_sample_in >= thr_reg.input_current_start_high &&
          output_current_sample_in >= thr_reg.output_current_start_high) begin
        track_next = 1'b1;
      end
    end else if (input_current_sample_in < thr_reg.input_current_start_low ||
                 output_current_sample_in < thr_reg.output_current_start_low) begin
      track_next = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      strap_meta_reg <= 3'h0;
      strap_reg <= 3'h0;
      addr_reg <= 7'h0;
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 3'h0;
      byte_idx_reg <= 4'h0;
      shift_reg <= 8'h0;
      rw_reg <= 1'b0;
      cmd_reg <= CMD_BASE;
      wbuf_reg <= 56'h0;
      tx_reg <= 56'h0;
      oe_reg <= 1'b0;
      wr_reg <= 1'b0;
      track_reg <= 1'b0;
      limits_reg <= '0;
      ovr_reg <= 1'b0;
      duty_reg <= 9'h0;
      trim_reg <= '0;
      thr_reg <= mppt_thresh_s'(THRESH_RESET[THR_LSB +: 40]);  // Zero would fake an entry
    end else begin
      scl_sync_reg <= scl_sync_next;
      sda_sync_reg <= sda_sync_next;
      strap_meta_reg <= strap_meta_next;
      strap_reg <= strap_next;
      addr_reg <= addr_next;
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      byte_idx_reg <= byte_idx_next;
      shift_reg <= shift_next;
      rw_reg <= rw_next;
      cmd_reg <= cmd_next;
      wbuf_reg <= wbuf_next;
      tx_reg <= tx_next;
      oe_reg <= oe_next;
      wr_reg <= wr_next;
      track_reg <= track_next;
      limits_reg <= limits_next;
      ovr_reg <= ovr_next;
      duty_reg <= duty_next;
      trim_reg <= trim_next;
      thr_reg <= thr_next;
    end
  end

  // Open-drain: data only ever pulled low
  assign sda_out = 1'b0;
  assign sda_oe_out = oe_reg;
  assign limits_out = limits_reg;
  assign override_out = ovr_reg;
  assign pwm_duty_out = duty_reg;
  assign trim_out = trim_reg;
  assign thresh_out = thr_reg;
  assign tracking_out = track_reg;

endmodule

`default_nettype wire

// ===== sim/mppt_i2c_master.sv
// Serial bus master model: drives the clock and pulls the open-drain data line
`timescale 1ns/1ps
`default_nettype none

module mppt_i2c_master #(
  parameter int HALF_CLKS = 200  // Core clocks per bus clock level
) (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  // Idle bus: both lines left to the pull-up
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end

  // One bus clock level
  task automatic hold();
    repeat (HALF_CLKS) @(posedge clk_in);
  endtask

  // Start or repeated start: data falls while the clock is high
  task automatic start();
    sda_low_out <= 1'b0;
    hold();
    scl_out <= 1'b1;
    hold();
    sda_low_out <= 1'b1;
    hold();
    scl_out <= 1'b0;
    hold();
  endtask

  // Stop: data rises while the clock is high
  task automatic stop();
    sda_low_out <= 1'b1;
    hold();
    scl_out <= 1'b1;
    hold();
    sda_low_out <= 1'b0;
    hold();
  endtask

  // Data moves only in the low phase, so no false start or stop is seen
  task automatic bit_io(input logic b, output logic r);
    sda_low_out <= !b;
    hold();
    scl_out <= 1'b1;
    hold();
    r = sda_in;
    scl_out <= 1'b0;
    hold();
  endtask

  // Byte out, MSB first; ack true when the slave pulls the ninth bit
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask

  // Byte in; the master refuses the last one
  task automatic rd_byte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule
`default_nettype wire

// ===== sim/mppt_i2c_register_access_asserts.sv
// Checker for the register access block, bound to its top module
`timescale 1ns/1ps
`default_nettype none

module mppt_i2c_register_access_asserts
  import mppt_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic [9:0] input_current_sample_in,
  input wire logic [9:0] output_current_sample_in,
  input wire mppt_limits_s sensed_limits_in,
  input wire mppt_limits_s limits_out,
  input wire logic override_out,
  input wire logic [8:0] pwm_duty_out,
  input wire mppt_trim_s trim_out,
  input wire mppt_thresh_s thresh_out,
  input wire logic tracking_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (srst_in);

  logic [2:0] rst_age_reg;       // Cycles since reset, saturating
  mppt_thresh_s thr_d1_reg;      // Threshold history
  mppt_thresh_s thr_d2_reg;
  logic settled;                 // Reset values have landed
  logic thr_steady;              // Thresholds unchanged for three cycles
  logic enter_ok;
  logic exit_ok;

  // Helper history registers
  always_ff @(posedge core_clk_in) begin
    rst_age_reg <= srst_in ? 3'h0 : rst_age_reg + {2'h0, rst_age_reg != 3'h7};
    thr_d1_reg <= thresh_out;
    thr_d2_reg <= thr_d1_reg;
  end
  assign settled = (rst_age_reg == 3'h7);
  assign thr_steady = (thresh_out == thr_d1_reg) && (thr_d1_reg == thr_d2_reg);
  assign enter_ok = (input_current_sample_in >= thresh_out.input_current_start_high) &&
    (output_current_sample_in >= thresh_out.output_current_start_high);
  assign exit_ok = (input_current_sample_in < thresh_out.input_current_start_low) ||
    (output_current_sample_in < thresh_out.output_current_start_low);

  sequence s_rel;
    $fell(srst_in);
  endsequence
  sequence s_quiet;
    settled ##1 !override_out;
  endsequence

  property p_sda_zero;
    sda_out == 1'b0;
  endproperty
  property p_oe_low_phase;
    $changed(sda_oe_out) && settled |-> !scl_in;
  endproperty
  property p_thresh_reset;
    s_rel |-> ##[0:3] (thresh_out == THRESH_RESET[39:0]);
  endproperty
  property p_duty_reset;
    s_rel |-> ##[0:3] (pwm_duty_out == CTRL_RESET[13:5]);
  endproperty
  property p_commit;
    ($changed(trim_out) || $changed(thresh_out) || $changed(pwm_duty_out)) && settled
      |-> !scl_in;
  endproperty
  property p_enter;
    enter_ok && !exit_ok && thr_steady && settled |=> tracking_out;
  endproperty
  property p_exit;
    exit_ok && thr_steady && settled |=> !tracking_out;
  endproperty
  property p_limits;
    s_quiet |-> (limits_out == $past(sensed_limits_in));
  endproperty

  a_sda_zero: assert property (p_sda_zero) else $error("data value not low");
  a_oe_low_phase: assert property (p_oe_low_phase) else $error("data moved in high");
  a_thresh_reset: assert property (p_thresh_reset) else $error("threshold reset");
  a_duty_reset: assert property (p_duty_reset) else $error("duty reset value");
  a_commit: assert property (p_commit) else $error("register changed mid bit");
  a_enter: assert property (p_enter) else $error("tracking not entered");
  a_exit: assert property (p_exit) else $error("tracking not left");
  a_limits: assert property (p_limits) else $error("sensed limits not used");
endmodule

bind mppt_i2c_register_access mppt_i2c_register_access_asserts u_asserts (
  .core_clk_in(core_clk_in), .srst_in(srst_in), .scl_in(scl_in), .sda_out(sda_out),
  .sda_oe_out(sda_oe_out), .input_current_sample_in(input_current_sample_in),
  .output_current_sample_in(output_current_sample_in), .sensed_limits_in(sensed_limits_in),
  .limits_out(limits_out), .override_out(override_out), .pwm_duty_out(pwm_duty_out),
  .trim_out(trim_out), .thresh_out(thresh_out), .tracking_out(tracking_out));
`default_nettype wire

// ===== sim/mppt_i2c_register_access_tb.sv
// Self-checking bench for the register access block
`timescale 1ns/1ps
`default_nettype none

module mppt_i2c_register_access_tb import mppt_pkg::*;;
  // ------------------------------------------------------------
  // Stimulus values
  // ------------------------------------------------------------
  // the only device on the bus, strap address 6
  localparam logic [6:0] DEV_ADDR = 7'h06;
  localparam logic [7:0] ACK_MAP = 8'h3b;  // Commands that are accepted
  localparam logic [55:0] TRIM_VAL = 56'hc3_b2a1_9f8e_7d6c;
  localparam logic [55:0] THR_VAL = {16'h0, 10'd100, 10'd50, 10'd80, 10'd30};
  localparam logic [55:0] CTRL_A = {9'h0, 1'b1, 3'h0, 1'b1, 2'h2, 10'h155, 10'h2aa, 6'h0,
    9'h1a5, 5'h0};
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [2:0] strap = 3'h6;
  logic [9:0] iin = 10'h000;
  logic [9:0] iout = 10'h000;
  mppt_limits_s sensed = 23'h3a_5c3d;
  logic [55:0] status0 = 56'h66_5544_3322_1100;
  logic [55:0] status1 = 56'h0f_1e2d_3c4b_5a69;
  logic scl;
  logic m_low;       // Master pulls data low
  logic sda_o;
  logic sda_oe;
  logic sda_line;    // Wired-and level with pull-up
  mppt_limits_s limits;
  logic override;
  logic [8:0] duty;
  mppt_trim_s trim;
  mppt_thresh_s thresh;
  logic tracking;
  int error_cnt = 0;
  int n_checks = 0;

  always #12.5 clk = ~clk;
  assign sda_line = !((sda_oe && !sda_o) || m_low);

  mppt_i2c_register_access u_mppt_i2c_register_access (
    .core_clk_in(clk), .srst_in(srst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_o),
    .sda_oe_out(sda_oe), .addr_strap_msb(strap[2]), .addr_strap_mid(strap[1]),
    .addr_strap_lsb(strap[0]), .input_current_sample_in(iin), .output_current_sample_in(iout),
    .status0_in(status0), .status1_in(status1), .sensed_limits_in(sensed), .limits_out(limits),
    .override_out(override), .pwm_duty_out(duty), .trim_out(trim), .thresh_out(thresh),
    .tracking_out(tracking));

  // Faster bus keeps the run short; levels stay well above four clocks
  mppt_i2c_master #(.HALF_CLKS(8)) u_mppt_i2c_master (
    .clk_in(clk), .sda_in(sda_line), .scl_out(scl), .sda_low_out(m_low));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [55:0] seen, input logic [55:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Write of n data bytes, least significant first; ok when all acked
  task automatic wr_reg(input logic [7:0] cmd, input logic [55:0] d, input int n,
      output logic ok);
    logic k;
    u_mppt_i2c_master.start();
    u_mppt_i2c_master.wr_byte({DEV_ADDR, 1'b0}, ok);
    u_mppt_i2c_master.wr_byte(cmd, k);
    ok = ok & k;
    for (int i = 0; i < n; i++) begin
      u_mppt_i2c_master.wr_byte(d[8*i +: 8], k);
      ok = ok & k;
    end
    u_mppt_i2c_master.stop();
    repeat (8) @(posedge clk);
  endtask

  // Command write, repeated start, then a seven byte read
  task automatic rd_reg(input logic [7:0] cmd, output logic [55:0] d);
    logic k;
    u_mppt_i2c_master.start();
    u_mppt_i2c_master.wr_byte({DEV_ADDR, 1'b0}, k);
    u_mppt_i2c_master.wr_byte(cmd, k);
    u_mppt_i2c_master.start();
    u_mppt_i2c_master.wr_byte({DEV_ADDR, 1'b1}, k);
    for (int i = 0; i < 7; i++) begin
      u_mppt_i2c_master.rd_byte(i == 6, d[8*i +: 8]);
    end
    u_mppt_i2c_master.stop();
  endtask

  // Drive current samples, then look at the tracking level
  task automatic samp(input logic [9:0] a, input logic [9:0] b, input logic exp);
    @(posedge clk);
    iin <= a;
    iout <= b;
    repeat (3) @(posedge clk);
    check({55'h0, tracking}, {55'h0, exp});
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset_vals();
    logic [55:0] d;
    check({24'h0, trim}, 56'h0);
    check({16'h0, thresh}, THRESH_RESET);
    check({47'h0, duty}, {47'h0, CTRL_RESET[13:5]});
    rd_reg(CMD_BASE + 8'h05, d);
    check(d, THRESH_RESET);
  endtask

  // Bit-reversed strap address must be ignored
  task automatic t_address();
    logic k;
    u_mppt_i2c_master.start();
    u_mppt_i2c_master.wr_byte({7'h03, 1'b0}, k);
    u_mppt_i2c_master.stop();
    check({55'h0, k}, 56'h0);
  endtask

  // Every command code from the base upward
  task automatic t_commands();
    logic k;
    for (int i = 0; i < 8; i++) begin
      u_mppt_i2c_master.start();
      u_mppt_i2c_master.wr_byte({DEV_ADDR, 1'b0}, k);
      u_mppt_i2c_master.wr_byte(CMD_BASE + 8'(i), k);
      u_mppt_i2c_master.stop();
      check({55'h0, k}, {55'h0, ACK_MAP[i]});
    end
  endtask

  // Full write, read back, then a short write that must not land
  task automatic t_trim();
    logic ok;
    logic [55:0] d;
    wr_reg(CMD_BASE + 8'h04, TRIM_VAL, 7, ok);
    check({55'h0, ok}, 56'h1);
    check({24'h0, trim}, {24'h0, TRIM_VAL[31:0]});
    rd_reg(CMD_BASE + 8'h04, d);
    check(d, TRIM_VAL);
    wr_reg(CMD_BASE + 8'h04, ~TRIM_VAL, 4, ok);
    check({24'h0, trim}, {24'h0, TRIM_VAL[31:0]});
    rd_reg(CMD_BASE + 8'h04, d);
    check(d, TRIM_VAL);
  endtask

  // Thresholds at their boundaries, entering and leaving tracking
  task automatic t_thresh();
    logic ok;
    wr_reg(CMD_BASE + 8'h05, THR_VAL, 7, ok);
    check({16'h0, thresh}, THR_VAL);
    samp(10'd99, 10'd80, 1'b0);
    samp(10'd100, 10'd80, 1'b1);
    samp(10'd50, 10'd30, 1'b1);
    samp(10'd50, 10'd29, 1'b0);
    samp(10'd200, 10'd79, 1'b0);
  endtask

  // Read-only register 0 ignores a write; both read-only registers read back
  task automatic t_readonly();
    logic ok;
    logic [55:0] d;
    wr_reg(CMD_BASE, ~status0, 7, ok);
    rd_reg(CMD_BASE, d);
    check(d, status0);
    rd_reg(CMD_BASE + 8'h01, d);
    check(d, status1);
  endtask

  // Duty and override limits, then override cleared
  task automatic t_ctrl();
    logic ok;
    logic [55:0] d;
    wr_reg(CMD_BASE + 8'h03, CTRL_A, 7, ok);
    check({55'h0, override}, 56'h1);
    check({47'h0, duty}, 56'h1a5);
    check({33'h0, limits}, {33'h0, 1'b1, 2'h2, 10'h155, 10'h2aa});
    wr_reg(CMD_BASE + 8'h03, CTRL_A ^ (56'h1 << 46), 7, ok);
    check({33'h0, limits}, {33'h0, sensed});
    rd_reg(CMD_BASE + 8'h03, d);
    check(d, CTRL_A ^ (56'h1 << 46));
  endtask

  // Hang guard
  initial begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    print_verdict();
  end

  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    repeat (10) @(posedge clk);
    t_reset_vals();
    t_address();
    t_commands();
    t_trim();
    t_thresh();
    t_readonly();
    t_ctrl();
    print_verdict();
  end
endmodule
`default_nettype wire
